// ### stage_info_regs.svh
`ifndef STAGE_INFO_REGS_SVH
`define STAGE_INFO_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses on APB).
`define OFS_BAUD 12'h000
`define OFS_SETUP 12'h004
`define OFS_BRAKE 12'h008
`define OFS_THERMAL 12'h00C
`define OFS_SWITCH 12'h010
`define OFS_MEM_ADDR 12'h014
`define OFS_MEM_DATA 12'h018
`define OFS_STATUS 12'h01C

// ==========================================================================
// Reset values.
`define RST_BAUD 32'h0001_C200
`define RST_SETUP 16'h0008
`define RST_FLAGS 32'h0000_0000

// ==========================================================================
// Command words, little-endian as they arrive on the byte stream.
`define CMD_IDENT 32'h6974_7367
`define CMD_SETTINGS 32'h7374_7367
`define CMD_SERIAL 32'h7472_7567
`define CMD_ACCESS 32'h6363_6173

// ==========================================================================
// Frame lengths and byte positions inside frames.
`define LEN_IDENT 8'h46
`define LEN_SETTINGS 8'h46
`define LEN_SERIAL 8'h10
`define LEN_ACK 8'h04
`define LEN_ACC_REQ 8'h72
`define STG_DATA_END 8'h2C
`define STG_CRC_LO 8'h44
`define SER_BAUD_END 8'h08
`define SER_SETUP_LO 8'h08
`define SER_CRC_LO 8'h0E
`define ACC_BRAKE_OFS 8'h28
`define ACC_THERM_OFS 8'h50
`define ACC_SWITCH_OFS 8'h54
`define ACC_RSV_OFS 8'h58
`define ACC_CRC_LO 8'h70

// ==========================================================================
// Store layout.
`define MEM_IDENT_BASE 8'h00
`define MEM_SET_BASE 8'h28
`define MEM_ACC_BASE 8'h50

// ==========================================================================
// Field positions.
`define PAR_SEL_LSB 0
`define PAR_USE_BIT 2
`define STOP_ONE_BIT 3
`define BRK_PRESENT_BIT 0
`define BRK_POWERED_BIT 1
`define TS_TYPE_LSB 0
`define TS_PRESENT_BIT 3
`define SW_A_PRES_BIT 0
`define SW_B_PRES_BIT 1
`define SW_A_LOW_BIT 2
`define SW_B_LOW_BIT 3
`define SW_JOIN_BIT 4
`define STAT_BUSY_BIT 0
`define STAT_CRCERR_BIT 1

`endif

// ### stage_info_pkg.sv
package stage_info_pkg;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RXP = 2'b01,
    ST_FETCH = 2'b11,
    ST_SEND = 2'b10
  } eng_state_t;

  typedef enum logic [1:0] {
    PAR_EVEN = 2'b00,
    PAR_ODD = 2'b01,
    PAR_ZERO = 2'b10,
    PAR_ONE = 2'b11
  } parity_t;

endpackage

// ### frame_store_mem.sv
`timescale 1ns/1ns
`default_nettype none

module frame_store_mem #(
  parameter int WIDTH = 8,
  parameter int AW = 8
) (
  // Clock.
  input wire logic clk,
  input wire logic ce,
  // Write port.
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port.
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read: data for an address appears one cycle later.
  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule

`default_nettype wire

// ### stage_info_cmd.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "stage_info_regs.svh"

// Behaviour
// - Command word 0x73747367 asks for stage settings and the reply opens with that word.
// - The settings reply carries pitch, an 8-char unit string and the seven float limits.
// - The identification reply carries a 16-char maker, a 24-char part string, 24 zero bytes.
// - Command word 0x74727567 returns baud rate, setup word, 4 reserved bytes, checksum.
// - Setup bits 1:0 pick even, odd, forced-0 or forced-1 parity.
// - Setup bit 0x4 is the parity-usage flag of the bit mask.
// - Setup bit 0x8 set gives one stop bit, clear gives two.
// - Command word 0x63636173 is a 114-byte accessory write ending in a checksum.
// - The accessory request opens with a 24-char brake string and three brake floats.
// - Brake word flag 0x1 means a brake is fitted and 0x2 that it holds when powered.
// - Thermal word bits 2:0 give the sensor type and flag 0x8 marks it present.
// - Switch word flags 0x1 and 0x2 mark switch inputs a and b present.
// - Switch word flag 0x10 joins both switch inputs into one shorted pair.
module stage_info_cmd (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command byte stream from the host link.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Reply byte stream to the host link.
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Serial framing.
  output stage_info_pkg::parity_t parity_sel,
  output logic parity_used,
  output logic stop_two,
  // Accessories.
  output logic brake_present_flag,
  output logic brake_engaged_when_powered_flag,
  output logic [2:0] thermal_sensor_type_field,
  output logic thermal_sensor_present_flag,
  // Limit switch pins and their decoded state.
  input wire logic end_switch_a_input,
  input wire logic end_switch_b_input,
  output logic end_switch_a_hit,
  output logic end_switch_b_hit
);
  import stage_info_pkg::*;

  // ==========================================================================
  // Decoding used only by the frame engine.
  function automatic logic [7:0] cmd_len(input logic [31:0] c);
    logic [7:0] n;
    n = 8'h00;
    unique case (c)
      `CMD_IDENT: n = `LEN_IDENT;
      `CMD_SETTINGS: n = `LEN_SETTINGS;
      `CMD_SERIAL: n = `LEN_SERIAL;
      `CMD_ACCESS: n = `LEN_ACK;
      default: n = 8'h00;
    endcase
    return n;
  endfunction

  function automatic logic [7:0] reply_byte(input logic [31:0] c, input logic [7:0] i,
      input logic [7:0] memb, input logic [15:0] sum, input logic [31:0] baud,
      input logic [15:0] setup);
    logic [7:0] b;
    b = 8'h00;
    if (i < 8'h04) begin
      b = c[{i[1:0], 3'b000} +: 8];
    end else if (c == `CMD_SERIAL) begin
      if (i < `SER_BAUD_END) begin
        b = baud[{i[1:0], 3'b000} +: 8];
      end else if (i == `SER_SETUP_LO) begin
        b = setup[7:0];
      end else if (i == `SER_SETUP_LO + 8'h01) begin
        b = setup[15:8];
      end else if (i == `SER_CRC_LO) begin
        b = sum[7:0];
      end else if (i == `SER_CRC_LO + 8'h01) begin
        b = sum[15:8];
      end
    end else if (c == `CMD_IDENT || c == `CMD_SETTINGS) begin
      if (i < `STG_DATA_END) begin
        b = memb;
      end else if (i == `STG_CRC_LO) begin
        b = sum[7:0];
      end else if (i == `STG_CRC_LO + 8'h01) begin
        b = sum[15:8];
      end
    end
    return b;
  endfunction

  // ==========================================================================
  // Engine state.
  eng_state_t state_r;
  logic [7:0] idx_r;
  logic [31:0] cmd_r;
  logic [15:0] sum_r;
  logic [7:0] crc_lo_r;
  logic fetch_wait_r;
  logic crc_err_r;
  logic [31:0] brake_sh_r, therm_sh_r, switch_sh_r;
  logic [31:0] brake_r, therm_r, switch_r;
  logic [31:0] baud_r;
  logic [15:0] setup_r;
  logic [7:0] mem_addr_r;
  logic [7:0] mem_rdata;
  logic busy;
  logic [31:0] cmd_full;
  logic [7:0] rlen;
  logic [7:0] eng_raddr;
  logic [7:0] eng_waddr;
  logic eng_we;
  logic apb_do;
  logic apb_wait_r;
  logic apb_mem_we;
  logic apb_wr;
  logic crc_ok;

  assign busy = (state_r != ST_IDLE) || (idx_r != 8'h00);
  assign cmd_full = {rx_data, cmd_r[31:8]};
  assign rlen = cmd_len(cmd_r);
  assign eng_raddr = ((cmd_r == `CMD_IDENT) ? `MEM_IDENT_BASE : `MEM_SET_BASE) + idx_r - 8'h04;
  assign eng_waddr = `MEM_ACC_BASE + idx_r - 8'h04;
  // Reserved request bytes never reach the store.
  assign eng_we = ce && state_r == ST_RXP && rx_valid && idx_r < `ACC_RSV_OFS;
  assign crc_ok = {rx_data, crc_lo_r} == sum_r;

  // Store owned by the engine while a frame is in flight, by software otherwise.
  frame_store_mem #(.WIDTH(8), .AW(8)) u_store (
    .clk(pclk),
    .ce(ce),
    .we(eng_we || apb_mem_we),
    .waddr(eng_we ? eng_waddr : mem_addr_r),
    .wdata(eng_we ? rx_data : pwdata[7:0]),
    .raddr(busy ? eng_raddr : mem_addr_r),
    .rdata(mem_rdata)
  );

  // ==========================================================================
  // Frame engine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      idx_r <= 8'h00;
      cmd_r <= 32'h0000_0000;
      sum_r <= 16'h0000;
      crc_lo_r <= 8'h00;
      fetch_wait_r <= 1'b0;
      rx_ready <= 1'b1;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (ce) begin
      unique case (state_r)
        ST_IDLE: begin
          if (rx_valid) begin
            cmd_r <= cmd_full;
            sum_r <= (idx_r == 8'h00) ? {8'h00, rx_data} : sum_r + {8'h00, rx_data};
            if (idx_r != 8'h03) begin
              idx_r <= idx_r + 8'h01;
            end else if (cmd_full == `CMD_ACCESS) begin
              idx_r <= 8'h04;
              state_r <= ST_RXP;
            end else if (cmd_len(cmd_full) != 8'h00) begin
              idx_r <= 8'h00;
              sum_r <= 16'h0000;
              rx_ready <= 1'b0;
              state_r <= ST_FETCH;
            end else begin
              // Unknown word: drop it and hunt for the next frame start.
              idx_r <= 8'h00;
            end
          end
        end
        ST_RXP: begin
          if (rx_valid) begin
            idx_r <= idx_r + 8'h01;
            if (idx_r < `ACC_CRC_LO) begin
              sum_r <= sum_r + {8'h00, rx_data};
            end
            if (idx_r == `ACC_CRC_LO) begin
              crc_lo_r <= rx_data;
            end
            if (idx_r == `LEN_ACC_REQ - 8'h01) begin
              idx_r <= 8'h00;
              sum_r <= 16'h0000;
              if (crc_ok) begin
                rx_ready <= 1'b0;
                state_r <= ST_FETCH;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
        end
        ST_FETCH: begin
          // Wait one cycle so the store has read the new address.
          fetch_wait_r <= !fetch_wait_r;
          if (fetch_wait_r) begin
            tx_data <= reply_byte(cmd_r, idx_r, mem_rdata, sum_r, baud_r, setup_r);
            tx_valid <= 1'b1;
            if (idx_r + 8'h02 < rlen) begin
              sum_r <= sum_r + {8'h00,
                  reply_byte(cmd_r, idx_r, mem_rdata, sum_r, baud_r, setup_r)};
            end
            state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            if (idx_r == rlen - 8'h01) begin
              idx_r <= 8'h00;
              rx_ready <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              idx_r <= idx_r + 8'h01;
              state_r <= ST_FETCH;
            end
          end
        end
      endcase
    end
  end

  // Flag words are staged while they arrive and only committed on a good checksum.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_sh_r <= `RST_FLAGS;
      therm_sh_r <= `RST_FLAGS;
      switch_sh_r <= `RST_FLAGS;
      brake_r <= `RST_FLAGS;
      therm_r <= `RST_FLAGS;
      switch_r <= `RST_FLAGS;
    end else if (ce && state_r == ST_RXP && rx_valid) begin
      if (idx_r[7:2] == `ACC_BRAKE_OFS >> 2) begin
        brake_sh_r[{idx_r[1:0], 3'b000} +: 8] <= rx_data;
      end
      if (idx_r[7:2] == `ACC_THERM_OFS >> 2) begin
        therm_sh_r[{idx_r[1:0], 3'b000} +: 8] <= rx_data;
      end
      if (idx_r[7:2] == `ACC_SWITCH_OFS >> 2) begin
        switch_sh_r[{idx_r[1:0], 3'b000} +: 8] <= rx_data;
      end
      if (idx_r == `LEN_ACC_REQ - 8'h01 && crc_ok) begin
        brake_r <= brake_sh_r;
        therm_r <= therm_sh_r;
        switch_r <= switch_sh_r;
      end
    end
  end

  // ==========================================================================
  // APB slave: one wait state; store accesses take two and also wait until the engine is idle.
  assign apb_do = psel && penable && !pready && !(paddr == `OFS_MEM_DATA && (busy || !apb_wait_r));
  // Writes land at the edge where the master sees pready, so a held request acts once.
  assign apb_wr = ce && psel && penable && pready && pwrite;
  assign apb_mem_we = apb_wr && paddr == `OFS_MEM_DATA;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      apb_wait_r <= 1'b0;
      baud_r <= `RST_BAUD;
      setup_r <= `RST_SETUP;
      mem_addr_r <= 8'h00;
      crc_err_r <= 1'b0;
    end else if (ce) begin
      pready <= apb_do;
      apb_wait_r <= psel && penable && !pready && !busy;
      if (apb_do) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        unique case (paddr)
          `OFS_BAUD: if (!pwrite) prdata <= baud_r;
          `OFS_SETUP: if (!pwrite) prdata <= {16'h0000, setup_r};
          `OFS_BRAKE: if (!pwrite) prdata <= brake_r;
          `OFS_THERMAL: if (!pwrite) prdata <= therm_r;
          `OFS_SWITCH: if (!pwrite) prdata <= switch_r;
          `OFS_MEM_ADDR: if (!pwrite) prdata <= {24'h00_0000, mem_addr_r};
          `OFS_MEM_DATA: if (!pwrite) prdata <= {24'h00_0000, mem_rdata};
          `OFS_STATUS: begin
            prdata[`STAT_BUSY_BIT] <= busy;
            prdata[`STAT_CRCERR_BIT] <= crc_err_r;
          end
          default: pslverr <= 1'b1;
        endcase
      end
      if (apb_wr) begin
        unique case (paddr)
          `OFS_BAUD: baud_r <= pwdata;
          `OFS_SETUP: setup_r <= pwdata[15:0];
          `OFS_MEM_ADDR: mem_addr_r <= pwdata[7:0];
          `OFS_MEM_DATA: mem_addr_r <= mem_addr_r + 8'h01;
          default: ;
        endcase
      end
      // A checksum failure in the same cycle as a clear keeps the flag set.
      if (state_r == ST_RXP && rx_valid && idx_r == `LEN_ACC_REQ - 8'h01 && !crc_ok) begin
        crc_err_r <= 1'b1;
      end else if (apb_wr && paddr == `OFS_STATUS && pwdata[`STAT_CRCERR_BIT]) begin
        crc_err_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Decoded settings and limit switches.
  logic [1:0] sw_meta_r, sw_sync_r, sw_trig;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_r <= 2'b00;
      sw_sync_r <= 2'b00;
    end else if (ce) begin
      sw_meta_r <= {end_switch_b_input, end_switch_a_input};
      sw_sync_r <= sw_meta_r;
    end
  end

  // Each input is inverted when its low-active flag is set.
  for (genvar g = 0; g < 2; g++) begin : g_trig
    assign sw_trig[g] = sw_sync_r[g] ^ switch_r[`SW_A_LOW_BIT + g];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_sel <= PAR_EVEN;
      parity_used <= 1'b0;
      stop_two <= 1'b0;
      brake_present_flag <= 1'b0;
      brake_engaged_when_powered_flag <= 1'b0;
      thermal_sensor_type_field <= 3'b000;
      thermal_sensor_present_flag <= 1'b0;
      end_switch_a_hit <= 1'b0;
      end_switch_b_hit <= 1'b0;
    end else if (ce) begin
      parity_sel <= parity_t'(setup_r[`PAR_SEL_LSB +: 2]);
      parity_used <= setup_r[`PAR_USE_BIT];
      stop_two <= !setup_r[`STOP_ONE_BIT];
      brake_present_flag <= brake_r[`BRK_PRESENT_BIT];
      brake_engaged_when_powered_flag <= brake_r[`BRK_POWERED_BIT];
      thermal_sensor_type_field <= therm_r[`TS_TYPE_LSB +: 3];
      thermal_sensor_present_flag <= therm_r[`TS_PRESENT_BIT];
      // A joined pair trips each present switch when either side trips.
      end_switch_a_hit <= switch_r[`SW_A_PRES_BIT] &&
          (switch_r[`SW_JOIN_BIT] ? |sw_trig : sw_trig[0]);
      end_switch_b_hit <= switch_r[`SW_B_PRES_BIT] &&
          (switch_r[`SW_JOIN_BIT] ? |sw_trig : sw_trig[1]);
    end
  end

  // ==========================================================================
  // Checks.
  chk_echo_first: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_r == ST_FETCH && fetch_wait_r && idx_r == 8'h00 |=> tx_data == cmd_r[7:0])
    else $error("reply does not open with the command word");
  chk_settings_len: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_r == ST_SEND && tx_ready && cmd_r == `CMD_SETTINGS && rx_ready == 1'b0
      ##0 $past(state_r) == ST_SEND |-> idx_r <= 8'h45)
    else $error("settings reply longer than 70 bytes");
  chk_ident_rsv: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_SEND && cmd_r == `CMD_IDENT && idx_r >= 8'h2C && idx_r < 8'h44
      |-> tx_data == 8'h00)
    else $error("identification reserved byte not zero");
  chk_serial_end: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_r == ST_SEND && tx_ready && cmd_r == `CMD_SERIAL && idx_r == 8'h0F
      |=> state_r == ST_IDLE && rx_ready)
    else $error("serial reply did not end after 16 bytes");
  chk_parity_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ce && $stable(setup_r) ##1 ce |-> parity_sel == parity_t'($past(setup_r[1:0])) &&
      parity_used == $past(setup_r[2]))
    else $error("parity outputs do not follow the setup word");
  chk_stop_bits: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_r[3] ##1 ce && setup_r[3] |-> !stop_two)
    else $error("two stop bits chosen while one was asked");
  chk_ack_start: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_r == ST_RXP && rx_valid && idx_r == 8'h71 && crc_ok
      |=> state_r == ST_FETCH ##[1:8] tx_valid && tx_data == 8'h73)
    else $error("good accessory write not acknowledged");
  chk_switch_present: assert property (@(posedge pclk) disable iff (!presetn)
    end_switch_a_hit && ce ##1 ce |-> $past(switch_r[0], 2) || switch_r[0])
    else $error("absent switch reported as hit");
  chk_switch_joined: assert property (@(posedge pclk) disable iff (!presetn)
    ce && switch_r[4] && switch_r[1:0] == 2'b11 && $stable(switch_r) ##1 ce
      |-> end_switch_a_hit == end_switch_b_hit)
    else $error("joined switches disagree");
  chk_ack_len: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_SEND && cmd_r == `CMD_ACCESS |-> idx_r < 8'h04)
    else $error("acknowledge longer than 4 bytes");

endmodule

`default_nettype wire

// ### host_link_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Host end of the byte link.
module host_link_model (
  // Clock.
  input wire logic pclk,
  // Request stream.
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Reply stream.
  input wire logic tx_valid,
  output logic tx_ready,
  // Pacing.
  input wire logic slow
);
  logic [2:0] pace_r = 3'h0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // A slow host leaves a reply byte waiting for up to eight cycles.
  always @(posedge pclk) begin
    pace_r <= pace_r + 3'h1;
    tx_ready <= !slow || pace_r == 3'h0;
  end

  // Holds the byte until the edge that takes it; the next call may follow at once.
  task automatic send(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    do @(posedge pclk); while (rx_ready !== 1'b1);
  endtask

  // The released data lines show the inverse so stale bytes never look valid.
  task automatic idle();
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

`default_nettype wire

// ### tb_stage_info_cmd.sv
`timescale 1ns/1ns
`default_nettype none

module tb_stage_info_cmd;
  import stage_info_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  parity_t parity_sel;
  logic parity_used, stop_two, brk_a, brk_b, ts_p, hit_a, hit_b;
  logic slow = 1'b0;
  logic sw_a = 1'b0;
  logic sw_b = 1'b0;
  logic [2:0] ts_type;
  logic [7:0] exp_q[$];
  logic [31:0] rnd = 32'h0000_6915;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #20 pclk = ~pclk;

  stage_info_cmd stage_info_cmd_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .parity_sel(parity_sel), .parity_used(parity_used), .stop_two(stop_two),
    .brake_present_flag(brk_a), .brake_engaged_when_powered_flag(brk_b),
    .thermal_sensor_type_field(ts_type), .thermal_sensor_present_flag(ts_p),
    .end_switch_a_input(sw_a), .end_switch_b_input(sw_b), .end_switch_a_hit(hit_a),
    .end_switch_b_hit(hit_b));

  host_link_model host_link_model_i (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));

  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // Every byte the host takes must match the oldest expected one.
  always @(posedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) check("spare reply byte", tx_data, 32'h0000_0100);
      else check("reply byte", tx_data, exp_q.pop_front());
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(what, r, exp);
  endtask

  // Notes the reply bytes, adding the additive checksum low byte first when asked.
  task automatic expect_bytes(input logic [7:0] b[$], input logic crc);
    logic [15:0] s;
    s = 16'h0000;
    foreach (b[i]) begin
      exp_q.push_back(b[i]);
      s += b[i];
    end
    if (crc) begin
      exp_q.push_back(s[7:0]);
      exp_q.push_back(s[15:8]);
    end
  endtask

  // Mode 0 sends no checksum, 1 a good one, 2 a corrupted one.
  task automatic frame(input logic [7:0] b[$], input int mode);
    logic [15:0] s;
    s = (mode == 2) ? 16'h0001 : 16'h0000;
    foreach (b[i]) begin
      host_link_model_i.send(b[i]);
      s += b[i];
    end
    if (mode != 0) begin
      host_link_model_i.send(s[7:0]);
      host_link_model_i.send(s[15:8]);
    end
    host_link_model_i.idle();
  endtask

  task automatic drain();
    for (int n = 0; n < 2000 && exp_q.size() != 0; n++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    check("reply length", exp_q.size(), 32'h0000_0000);
  endtask

  // ==========================================================================
  // Scenarios.
  initial begin
    logic [31:0] r, bw, tw, sw, nbw, ntw, nsw;
    logic e, ta, tb;
    logic [7:0] f[$];
    bw = 32'h0000_0000;
    tw = 32'h0000_0000;
    sw = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("baud reset", 12'h000, 32'h0001_C200);
    rd_chk("setup reset", 12'h004, 32'h0000_0008);
    check("stop_two reset", stop_two, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000, r, e);
    check("unmapped error", e, 32'h0000_0001);
    check("unmapped data", r, 32'h0000_0000);
    $display("Test reset done");
    for (int m = 0; m < 16; m++) begin
      wr(12'h004, m);
      @(posedge pclk);
      check("parity_sel", parity_sel, m[1:0]);
      check("parity_used", parity_used, m[2]);
      check("stop_two", stop_two, !m[3]);
    end
    $display("Test serial flags done");
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      rnd = lfsr(rnd);
      wr(12'h000, rnd);
      wr(12'h004, {16'h0000, rnd[23:8]});
      expect_bytes('{8'h67, 8'h75, 8'h72, 8'h74, rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24],
        rnd[15:8], rnd[23:16], 8'h00, 8'h00, 8'h00, 8'h00}, 1'b1);
      frame('{8'h67, 8'h75, 8'h72, 8'h74}, 0);
      drain();
    end
    $display("Test serial read done");
    for (int k = 0; k < 2; k++) begin
      f = '{8'h67, 8'h73, 8'h74, k ? 8'h73 : 8'h69};
      wr(12'h014, k ? 32'h0000_0028 : 32'h0000_0000);
      for (int i = 0; i < 40; i++) begin
        rnd = lfsr(rnd);
        wr(12'h018, {24'h00_0000, rnd[7:0]});
        f.push_back(rnd[7:0]);
      end
      repeat (24) f.push_back(8'h00);
      expect_bytes(f, 1'b1);
      frame(f[0:3], 0);
      drain();
    end
    $display("Test stage reads done");
    for (int t = 0; t < 4; t++) begin
      f = '{8'h73, 8'h61, 8'h63, 8'h63};
      for (int i = 4; i < 112; i++) begin
        rnd = lfsr(rnd);
        f.push_back(rnd[7:0]);
      end
      f[84][4] = t[0];
      nbw = {f[43], f[42], f[41], f[40]};
      ntw = {f[83], f[82], f[81], f[80]};
      nsw = {f[87], f[86], f[85], f[84]};
      if (t < 3) begin
        expect_bytes(f[0:3], 1'b0);
        frame(f, 1);
        bw = nbw;
        tw = ntw;
        sw = nsw;
      end else begin
        frame(f, 2);
      end
      drain();
      check("brake fitted", brk_a, bw[0]);
      check("brake powered", brk_b, bw[1]);
      check("sensor type", ts_type, tw[2:0]);
      check("sensor present", ts_p, tw[3]);
      rd_chk("brake word", 12'h008, bw);
      rd_chk("thermal word", 12'h00C, tw);
      rd_chk("switch word", 12'h010, sw);
      for (int j = 0; j < 4; j++) begin
        sw_a <= j[0];
        sw_b <= j[1];
        repeat (6) @(posedge pclk);
        ta = j[0] ^ sw[2];
        tb = j[1] ^ sw[3];
        check("switch a hit", hit_a, sw[0] & (sw[4] ? (ta | tb) : ta));
        check("switch b hit", hit_b, sw[1] & (sw[4] ? (ta | tb) : tb));
      end
    end
    rd_chk("checksum error", 12'h01C, 32'h0000_0002);
    wr(12'h01C, 32'h0000_0002);
    rd_chk("error cleared", 12'h01C, 32'h0000_0000);
    wr(12'h008, ~bw);
    rd_chk("brake word ro", 12'h008, bw);
    $display("Test accessory write done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
